// ===== core/cfg_protect_pkg.sv
package cfg_protect_pkg;
	// Printed word offsets, not multiples of four: kept as indexes
	localparam logic [15:0] idx_revision_ident = 16'h8005;
	localparam logic [15:0] idx_device_ident = 16'h8006;
	localparam logic [15:0] idx_partition_protect_word = 16'h800a;
	localparam logic [15:0] idx_code_protect_word = 16'h800b;
	// Status/control register of our own, at index 16'h8010
	localparam logic [15:0] idx_nv_status = 16'h8010;
	// Partition word fields
	localparam int pos_low_volt_prog_en = 13;
	localparam int pos_storage_area_wp_n = 11;
	localparam int pos_eeprom_wp_n = 10;
	localparam int pos_config_wp_n = 9;
	localparam int pos_boot_part_wp_n = 8;
	localparam int pos_app_part_wp_n = 7;
	localparam int pos_storage_area_en_n = 4;
	localparam int pos_boot_part_en_n = 3;
	localparam int pos_boot_size_lsb = 0;
	localparam int boot_size_w = 3;
	// Code protect word fields
	localparam int pos_eeprom_read_protect_n = 1;
	localparam int pos_progmem_read_protect_n = 0;
	// Writable bits and erased values
	localparam logic [15:0] partition_mask = 16'h2f9f;
	localparam logic [15:0] code_mask = 16'h0003;
	localparam logic [15:0] partition_erased = 16'h2f9f;
	localparam logic [15:0] code_erased = 16'h0003;
	// Identity register fixed bits
	localparam logic [1:0] device_ident_fixed = 2'h3;
	localparam logic [1:0] revision_fixed = 2'h2;
	// Memory map
	localparam int addr_w = 16;
	localparam logic [15:0] progmem_last = 16'h3fff;
	localparam logic [15:0] boot_half_end = 16'h3fff;
	localparam logic [15:0] storage_area_words = 16'h0080;
	localparam logic [15:0] eeprom_base = 16'hf000;
	localparam logic [15:0] eeprom_last = 16'hf0ff;
	localparam logic [15:0] config_base = 16'h8007;
	localparam logic [15:0] config_last = 16'h800b;
	// Write target kinds
	typedef enum logic [4:0]
	{
		region_app = 5'h01,
		region_boot = 5'h02,
		region_storage = 5'h04,
		region_config = 5'h08,
		region_eeprom = 5'h10
	} region_e;
endpackage

// ===== core/boot_size_decode.sv
`timescale 1ns/1ps
`default_nettype none
module boot_size_decode
(
	// Boot partition controls
	input wire logic boot_part_en_n,
	input wire logic [2:0] boot_part_size,
	// Decoded end address
	output logic boot_en,
	output logic [15:0] boot_end
);
	always_comb
	begin
		boot_en = !boot_part_en_n;
		case (boot_part_size)
			3'h7: boot_end = 16'h01ff;
			3'h6: boot_end = 16'h03ff;
			3'h5: boot_end = 16'h07ff;
			3'h4: boot_end = 16'h0fff;
			3'h3: boot_end = 16'h1fff;
			default: boot_end = cfg_protect_pkg::boot_half_end;
		endcase
	end
endmodule
`default_nettype wire

// ===== core/config_word_protection_decode.sv
// Operation
// - Low-voltage enable forces reset pin as reset
// - Low-voltage enable not clearable during LV programming
// - Storage area write-protect when enabled
// - EEPROM write-protect bit blocks writes
// - Config write-protect bit blocks config writes
// - Boot write-protect when boot enabled
// - Application write-protect bit blocks writes
// - Write protection removed only by bulk erase
// - Storage area enable is active low
// - Boot partition enable is active low
// - Size codes 111..011 give 512..8192 words
// - Smaller codes clamp to half memory (here: 16'h3fff, the whole memory)
// - Boot size fixed once boot enabled
// - EEPROM read protect active low
// - Program memory read protect active low
// - Code protection removed only by bulk erase
// - Device identity read-only, bits 13:12 ones
// - Revision read-only, fixed 10, major, minor
// - Storage area is top 128 words, no execution
// - Protected write sets write error flag
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module config_word_protection_decode
#(
	parameter logic [11:0] device_ident_value = 12'h5a5, // arbitrary
	parameter logic [5:0] major_rev_value = 6'h01, // arbitrary
	parameter logic [5:0] minor_rev_value = 6'h02 // arbitrary
)
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [17:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Nonvolatile words seen at reset
	input wire logic [15:0] nv_partition_word,
	input wire logic [15:0] nv_code_word,
	// Programming state
	input wire logic lv_prog_active,
	input wire logic bulk_erase,
	input wire logic reset_pin_enable,
	// Memory write check
	input wire logic wr_req,
	input wire logic [15:0] wr_addr,
	// Decoded controls
	output logic low_volt_prog_en,
	output logic reset_pin_is_reset,
	output logic hv_entry_required,
	output logic storage_area_en,
	output logic boot_en,
	output logic [15:0] boot_end,
	output logic [15:0] storage_base,
	output logic eeprom_read_protect,
	output logic progmem_read_protect,
	output logic wr_allow,
	output logic write_error_flag,
	output logic exec_forbidden
);
	logic [15:0] part_word;
	logic [15:0] code_word;
	logic loaded;
	logic err_flag;
	logic [15:0] next_part_word;
	logic [15:0] next_code_word;
	logic next_loaded;
	logic next_err_flag;
	logic [31:0] next_prdata;
	logic [15:0] reg_idx;
	logic apb_wr;
	logic apb_rd;
	logic hit;
	logic [15:0] wdata;
	logic [15:0] part_keep;
	logic wr_blocked;
	logic region_wp;
	cfg_protect_pkg::region_e region;
	logic [15:0] status_word;
	logic [0:0] pin_raw;
	logic [0:0] pin_level;

	boot_size_decode u_boot
	(
		.boot_part_en_n(part_word[cfg_protect_pkg::pos_boot_part_en_n]),
		.boot_part_size(part_word[2:0]),
		.boot_en(boot_en),
		.boot_end(boot_end)
	);

	assign reg_idx = paddr[17:2];
	assign apb_wr = psel && penable && pwrite;
	// Read data captured in setup, so it stands in the access phase
	assign apb_rd = psel && !penable && !pwrite;
	assign wdata = pwdata[15:0];
	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit;
	assign status_word = {14'h0000, loaded, err_flag};

	// Pad-level settings pass three stages each
	assign pin_raw[0] = reset_pin_enable;

	generate
		for (genvar i = 0; i < 1; i++)
		begin : g_pin_sync
			logic [2:0] stages;
			logic [2:0] next_stages;
			logic level;
			logic next_level;

			always_comb
			begin
				next_stages = {stages[1:0], pin_raw[i]};
				next_level = level;
				// Level follows only once second and third stages agree
				if (stages[1] == stages[2])
					next_level = stages[2];
			end

			always_ff @(posedge ref_clk)
			begin
				if (!rst_b)
				begin
					stages <= 3'h0;
					level <= 1'b0;
				end
				else
				begin
					stages <= next_stages;
					level <= next_level;
				end
			end

			assign pin_level[i] = level;
		end
	endgenerate

	always_comb
	begin
		hit = 1'b0;
		if (reg_idx == cfg_protect_pkg::idx_revision_ident)
			hit = 1'b1;
		else if (reg_idx == cfg_protect_pkg::idx_device_ident)
			hit = 1'b1;
		else if (reg_idx == cfg_protect_pkg::idx_partition_protect_word)
			hit = 1'b1;
		else if (reg_idx == cfg_protect_pkg::idx_code_protect_word)
			hit = 1'b1;
		else if (reg_idx == cfg_protect_pkg::idx_nv_status)
			hit = 1'b1;
	end

	// Decoded controls
	always_comb
	begin
		low_volt_prog_en = part_word[cfg_protect_pkg::pos_low_volt_prog_en];
		reset_pin_is_reset = low_volt_prog_en || pin_level[0];
		hv_entry_required = !low_volt_prog_en;
		storage_area_en =
			!part_word[cfg_protect_pkg::pos_storage_area_en_n];
		storage_base = cfg_protect_pkg::progmem_last
			- cfg_protect_pkg::storage_area_words + 16'h0001;
		eeprom_read_protect =
			!code_word[cfg_protect_pkg::pos_eeprom_read_protect_n];
		progmem_read_protect =
			!code_word[cfg_protect_pkg::pos_progmem_read_protect_n];
		write_error_flag = err_flag;
	end

	// Target region of a memory write
	always_comb
	begin
		if (wr_addr >= cfg_protect_pkg::eeprom_base
			&& wr_addr <= cfg_protect_pkg::eeprom_last)
			region = cfg_protect_pkg::region_eeprom;
		else if (wr_addr >= cfg_protect_pkg::config_base
			&& wr_addr <= cfg_protect_pkg::config_last)
			region = cfg_protect_pkg::region_config;
		else if (storage_area_en && wr_addr >= storage_base
			&& wr_addr <= cfg_protect_pkg::progmem_last)
			region = cfg_protect_pkg::region_storage;
		else if (boot_en && wr_addr <= boot_end)
			region = cfg_protect_pkg::region_boot;
		else
			region = cfg_protect_pkg::region_app;
	end

	always_comb
	begin
		case (region)
			cfg_protect_pkg::region_storage:
				region_wp = !part_word[cfg_protect_pkg::pos_storage_area_wp_n];
			cfg_protect_pkg::region_eeprom:
				region_wp = !part_word[cfg_protect_pkg::pos_eeprom_wp_n];
			cfg_protect_pkg::region_config:
				region_wp = !part_word[cfg_protect_pkg::pos_config_wp_n];
			cfg_protect_pkg::region_boot:
				region_wp = !part_word[cfg_protect_pkg::pos_boot_part_wp_n];
			default:
				region_wp = !part_word[cfg_protect_pkg::pos_app_part_wp_n];
		endcase
		wr_blocked = wr_req && region_wp;
		wr_allow = wr_req && !region_wp;
		exec_forbidden = storage_area_en && wr_addr >= storage_base
			&& wr_addr <= cfg_protect_pkg::progmem_last;
	end

	// Register update rules
	always_comb
	begin
		next_part_word = part_word;
		next_code_word = code_word;
		next_loaded = 1'b1;
		next_err_flag = err_flag;
		part_keep = wdata;
		// Protect bits only move toward protected: AND keeps zeros
		part_keep[11:7] = wdata[11:7] & part_word[11:7];
		if (lv_prog_active && part_word[cfg_protect_pkg::pos_low_volt_prog_en])
			part_keep[cfg_protect_pkg::pos_low_volt_prog_en] = 1'b1;
		if (boot_en)
			part_keep[2:0] = part_word[2:0];
		if (!loaded)
		begin
			next_part_word = nv_partition_word
				& cfg_protect_pkg::partition_mask;
			next_code_word = nv_code_word & cfg_protect_pkg::code_mask;
		end
		else if (bulk_erase)
		begin
			next_part_word = cfg_protect_pkg::partition_erased;
			next_code_word = cfg_protect_pkg::code_erased;
		end
		else if (apb_wr
			&& reg_idx == cfg_protect_pkg::idx_partition_protect_word
			&& part_word[cfg_protect_pkg::pos_config_wp_n])
			next_part_word = part_keep & cfg_protect_pkg::partition_mask;
		else if (apb_wr && reg_idx == cfg_protect_pkg::idx_code_protect_word
			&& part_word[cfg_protect_pkg::pos_config_wp_n])
			// Takes effect at once, hence written last by software
			next_code_word = wdata & code_word
				& cfg_protect_pkg::code_mask;
		// Blocked write sets the flag; set wins over a clear
		if (wr_blocked)
			next_err_flag = 1'b1;
		else if (apb_wr && reg_idx == cfg_protect_pkg::idx_nv_status
			&& wdata[0])
			next_err_flag = 1'b0;
	end

	// Read data
	always_comb
	begin
		next_prdata = 32'h0000_0000;
		if (!apb_rd)
			next_prdata = prdata;
		else if (reg_idx == cfg_protect_pkg::idx_revision_ident)
			next_prdata[13:0] = {cfg_protect_pkg::revision_fixed,
				major_rev_value, minor_rev_value};
		else if (reg_idx == cfg_protect_pkg::idx_device_ident)
			next_prdata[13:0] = {cfg_protect_pkg::device_ident_fixed,
				device_ident_value};
		else if (reg_idx == cfg_protect_pkg::idx_partition_protect_word)
			next_prdata[15:0] = part_word;
		else if (reg_idx == cfg_protect_pkg::idx_code_protect_word)
			next_prdata[15:0] = code_word;
		else if (reg_idx == cfg_protect_pkg::idx_nv_status)
			next_prdata[15:0] = status_word;
	end

	// Partition word
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
			part_word <= cfg_protect_pkg::partition_erased;
		else
			part_word <= next_part_word;
	end

	// Code protect word
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
			code_word <= cfg_protect_pkg::code_erased;
		else
			code_word <= next_code_word;
	end

	// Load marker, set at the first edge after reset
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
			loaded <= 1'b0;
		else
			loaded <= next_loaded;
	end

	// Sticky write error flag
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
			err_flag <= 1'b0;
		else
			err_flag <= next_err_flag;
	end

	// Read data, taken in setup and held until the next read
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
			prdata <= 32'h0000_0000;
		else
			prdata <= next_prdata;
	end
endmodule
`default_nettype wire

// ===== dv/cfg_protect_props.sv
`timescale 1ns/1ps
`default_nettype none
module cfg_protect_props
(
	// Bus and programming inputs
	input wire logic ref_clk, rst_b, psel, penable, pwrite, bulk_erase,
	input wire logic lv_prog_active, wr_req,
	input wire logic [17:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic [15:0] wr_addr, boot_end,
	// Decoded controls
	input wire logic low_volt_prog_en, reset_pin_is_reset, boot_en,
	input wire logic eeprom_read_protect, progmem_read_protect,
	input wire logic storage_area_en, wr_allow, write_error_flag,
	input wire logic exec_forbidden
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);
	sequence rd_at(logic [17:0] a);
		psel && penable && !pwrite && paddr == a;
	endsequence
	// Past the load edge, no erase
	sequence settled;
		$past(rst_b) && !bulk_erase;
	endsequence
	a_lvp_pin:
	assert property (low_volt_prog_en |-> reset_pin_is_reset)
		else $error("reset pin role wrong");
	a_lvp_keep:
	assert property (settled ##0 lv_prog_active && low_volt_prog_en
		|=> low_volt_prog_en) else $error("low-voltage enable cleared");
	a_size_frozen:
	assert property (settled ##0 boot_en |=> !boot_en || $stable(boot_end))
		else $error("boot size moved");
	a_cp_sticky:
	assert property (settled |=> $past(progmem_read_protect) <=
		progmem_read_protect && $past(eeprom_read_protect) <= eeprom_read_protect)
		else $error("read protection removed");
	a_erase_all:
	assert property (bulk_erase && !(psel && penable && pwrite) |=>
		low_volt_prog_en && !boot_en && !storage_area_en && !progmem_read_protect)
		else $error("erase incomplete");
	a_exec_sa:
	assert property (exec_forbidden == (storage_area_en && wr_addr >= 16'h3f80
		&& wr_addr <= 16'h3fff)) else $error("execution window wrong");
	a_err_set:
	assert property (wr_req && !wr_allow |=> write_error_flag)
		else $error("write error not flagged");
	a_dev_fixed:
	assert property (rd_at(18'h20018) |-> prdata[15:12] == 4'h3)
		else $error("device ident fixed bits");
	a_rev_fixed:
	assert property (rd_at(18'h20014) |-> prdata[15:12] == 4'h2)
		else $error("revision fixed bits");
endmodule
bind config_word_protection_decode cfg_protect_props i_cfg_protect_props (.*);
`default_nettype wire

// ===== dv/nv_partner.sv
`timescale 1ns/1ps
`default_nettype none
module nv_partner
(
	// Bench settings
	input wire logic ref_clk, prog_req, low_volt_prog_en,
	input wire logic [15:0] part_set, code_set,
	// Toward the block
	output logic [15:0] nv_partition_word, nv_code_word,
	output logic lv_prog_active
);
	always_ff @(posedge ref_clk)
	begin
		nv_partition_word <= part_set;
		nv_code_word <= code_set;
		// No low-voltage entry once disabled
		lv_prog_active <= prog_req && low_volt_prog_en;
	end
endmodule
`default_nettype wire

// ===== dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic ref_clk = 1'b0;
	logic rst_b, psel, penable, pwrite, pready, pslverr, err, flag, wr_req;
	logic bulk_erase, reset_pin_enable, prog_req, lv_prog_active, boot_en;
	logic low_volt_prog_en, reset_pin_is_reset, hv_entry_required;
	logic storage_area_en, eeprom_read_protect, progmem_read_protect;
	logic wr_allow, write_error_flag, exec_forbidden;
	logic [17:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] part_set, code_set, nv_partition_word, nv_code_word;
	logic [15:0] wr_addr, boot_end, w, r;
	logic [15:0] at [6];
	int n_errors = 0;
	int cmp_count = 0;
	int seed = 32'h1c542d11;
	config_word_protection_decode i_config_word_protection_decode
		(.*, .storage_base());
	nv_partner i_nv_partner (.*);
	initial forever #50 ref_clk = ~ref_clk;
	function automatic logic [15:0] boot_last(logic [2:0] s);
		return (s < 3'h3) ? 16'h3fff : 16'hffff >> s;
	endfunction
	function automatic logic may_write(logic [15:0] p, a);
		if (a >= 16'hf000) return p[10];
		if (a >= 16'h8000) return p[9];
		if (!p[4] && a >= 16'h3f80) return p[11];
		if (!p[3] && a <= boot_last(p[2:0])) return p[8];
		return p[7];
	endfunction
	task automatic cmp(string nm, logic [31:0] e, g);
		cmp_count++;
		n_errors += (g !== e);
		if (g !== e) $display("MISMATCH %s exp %h got %h", nm, e, g);
	endtask
	task automatic complete_run();
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic apb(logic wr, logic [17:0] a, logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		while (pready !== 1'b1 && n < 8)
		begin
			@(posedge ref_clk);
			n++;
		end
		// Answer taken at the edge where pready is seen high
		err = pslverr;
		rd = prdata;
		{psel, penable} <= 2'b00;
		if (n == 8)
		begin
			n_errors++;
			complete_run();
		end
	endtask
	task automatic boot_up(logic [15:0] p, c);
		@(posedge ref_clk);
		{rst_b, part_set, code_set, reset_pin_enable} <= {1'b0, p, c, p[0]};
		repeat (4) @(posedge ref_clk);
		rst_b <= 1'b1;
		repeat (2) @(posedge ref_clk);
	endtask
	initial
	begin
		{psel, penable, pwrite, bulk_erase, wr_req, prog_req, rst_b} = '0;
		{reset_pin_enable, paddr, pwdata, wr_addr, part_set, code_set} = '0;
		for (int k = 0; k < 8; k++)
		begin
			// Random words, every size code, boot block on
			w = 16'($random(seed)) & 16'h2f90 | 16'(k);
			boot_up(w, 16'(k & 3));
			apb(1'b0, 18'h20028, 32'h0);
			cmp("partition", 32'(w), rd);
			cmp("mode", {w[13] | w[0], !w[13], !w[4]},
				{reset_pin_is_reset, hv_entry_required, storage_area_en});
			cmp("protect", {!k[1], !k[0], 1'b1},
				{eeprom_read_protect, progmem_read_protect, boot_en});
			cmp("boot_end", boot_last(w[2:0]), boot_end);
			r = 16'($random(seed));
			at = '{16'hf000 | r[7:0], 16'h8008, 16'h3f80 | r[6:0],
				r & 16'h01ff, 16'h2000 | r[11:0], 16'h3fff};
			foreach (at[j])
			begin
				flag = write_error_flag;
				@(posedge ref_clk);
				{wr_req, wr_addr} <= {1'b1, at[j]};
				@(negedge ref_clk);
				cmp("allow", may_write(w, at[j]), wr_allow);
				cmp("exec", !w[4] && at[j] inside {[16'h3f80:16'h3fff]},
					exec_forbidden);
				@(posedge ref_clk);
				wr_req <= 1'b0;
				@(negedge ref_clk);
				cmp("flag", flag | !may_write(w, at[j]), write_error_flag);
			end
			apb(1'b1, 18'h20040, 32'h1);
			apb(1'b0, 18'h20040, 32'h0);
			cmp("status", 32'h2, rd);
		end
		apb(1'b1, 18'h20018, 32'h0);
		apb(1'b0, 18'h20018, 32'h0);
		cmp("device", 32'h35a5, rd);
		apb(1'b0, 18'h20014, 32'h0);
		cmp("revision", 32'h2042, rd);
		apb(1'b0, 18'h20100, 32'h0);
		cmp("unmapped", 32'h1, err);
		// Erased start, then protection and lock attempts
		boot_up(16'h2f9f, 16'h0003);
		cmp("boot_off", 32'h0, boot_en);
		prog_req <= 1'b1;
		apb(1'b1, 18'h20028, 32'h0f17);
		apb(1'b1, 18'h20028, 32'h2f90);
		apb(1'b0, 18'h20028, 32'h0);
		cmp("partition", 32'h2f17, rd);
		apb(1'b1, 18'h2002c, 32'h0);
		apb(1'b1, 18'h2002c, 32'h3);
		apb(1'b0, 18'h2002c, 32'h0);
		cmp("code", 32'h0, rd);
		cmp("read_prot", 32'h3,
			{eeprom_read_protect, progmem_read_protect});
		apb(1'b1, 18'h20028, 32'h2d17);
		apb(1'b1, 18'h20028, 32'h2d07);
		apb(1'b0, 18'h20028, 32'h0);
		cmp("locked", 32'h2d17, rd);
		@(posedge ref_clk);
		{bulk_erase, prog_req} <= 2'b10;
		@(posedge ref_clk);
		bulk_erase <= 1'b0;
		apb(1'b0, 18'h20028, 32'h0);
		cmp("erased", 32'h2f9f, rd);
		apb(1'b0, 18'h2002c, 32'h0);
		cmp("erased_code", 32'h3, rd);
		complete_run();
	end
endmodule
`default_nettype wire
